/* File: src/ocd_channel_cfg.sv */
// Register file and top level of the output channel divider and mux configuration block.
`timescale 1ns/10ps
module ocd_channel_cfg #(
	parameter int RATIO_W = 14,
	parameter int DELAY_W = 5
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic      [15:0] regRdData,
	output logic             regRdValid,
	input  wire logic        prescalerA,
	input  wire logic        prescalerB,
	input  wire logic        fracDivClk,
	input  wire logic        refClk,
	input  wire logic        syncReq,
	input  wire logic        calibActive,
	input  wire logic        muteOverride,
	input  wire logic        ch2Clk,
	input  wire logic        ch4Clk,
	output logic             outP,
	output logic             outN,
	output logic             outPEn,
	output logic             outNEn,
	output logic      [2:0]  outFormat,
	output logic             dividerPowered,
	output logic             syncBusy
);
	// ==========================================================
	// Register state
	logic [15:0] divCtrl_r, divCtrl_nxt;
	logic [15:0] outCtrl_r, outCtrl_nxt;
	logic [15:0] rdData_r, rdData_nxt;
	logic        rdValid_r, rdValid_nxt;
	logic        powered_r, powered_nxt;
	logic        busy_r, busy_nxt;

	ocd_cfg_if cfg ();

	// Reserved bit 9 is not stored, so the register reads back with it clear.
	function automatic logic [15:0] outCtrlMask(input logic [15:0] v);
		outCtrlMask = v & 16'hfdff;
	endfunction

	function automatic logic [15:0] readBack(input logic [7:0] a, input logic [15:0] d, input logic [15:0] o);
		case (a)
			ocd_pkg::ADDR_DIV_CTRL: readBack = d;
			ocd_pkg::ADDR_OUT_CTRL: readBack = outCtrlMask(o);
			default:                readBack = 16'h0000;
		endcase
	endfunction

	// ==========================================================
	// Register file
	always_comb begin
		divCtrl_nxt = divCtrl_r;
		outCtrl_nxt = outCtrl_r;
		if (regWrEn && regAddr == ocd_pkg::ADDR_DIV_CTRL) begin
			divCtrl_nxt = regWrData;
		end
		if (regWrEn && regAddr == ocd_pkg::ADDR_OUT_CTRL) begin
			outCtrl_nxt = outCtrlMask(regWrData);
		end
		rdValid_nxt = regRdEn;
		rdData_nxt  = regRdEn ? readBack(regAddr, divCtrl_r, outCtrl_r) : rdData_r;
		powered_nxt = (divCtrl_nxt[ocd_pkg::RATIO_MSB:ocd_pkg::RATIO_LSB] != '0);
		busy_nxt    = cfg.syncBusy;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			divCtrl_r <= ocd_pkg::DIV_CTRL_RESET;
			outCtrl_r <= ocd_pkg::OUT_CTRL_RESET;
			rdData_r  <= 16'h0000;
			rdValid_r <= 1'b0;
			powered_r <= 1'b0;
			busy_r    <= 1'b0;
		end else if (clkEn) begin
			divCtrl_r <= divCtrl_nxt;
			outCtrl_r <= outCtrl_nxt;
			rdData_r  <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
			powered_r <= powered_nxt;
			busy_r    <= busy_nxt;
		end
	end

	// ==========================================================
	// Field distribution
	assign cfg.srcSel    = divCtrl_r[ocd_pkg::SRC_MSB:ocd_pkg::SRC_LSB];
	assign cfg.ratio     = divCtrl_r[ocd_pkg::RATIO_MSB:ocd_pkg::RATIO_LSB];
	assign cfg.syncDelay = outCtrl_r[ocd_pkg::DLY_MSB:ocd_pkg::DLY_LSB];
	assign cfg.syncEn    = outCtrl_r[ocd_pkg::SYNCEN_BIT];
	assign cfg.muteLevel = outCtrl_r[ocd_pkg::MLVL_BIT];
	assign cfg.chanMute  = outCtrl_r[ocd_pkg::MUTE_BIT];
	assign cfg.override  = muteOverride;
	assign cfg.calib     = calibActive;
	assign cfg.pol       = outCtrl_r[ocd_pkg::POL_MSB:ocd_pkg::POL_LSB];
	assign cfg.fmt       = outCtrl_r[ocd_pkg::FMT_MSB:ocd_pkg::FMT_LSB];
	assign cfg.outSel    = outCtrl_r[ocd_pkg::OSEL_MSB:ocd_pkg::OSEL_LSB];

	assign regRdData      = rdData_r;
	assign regRdValid     = rdValid_r;
	assign outFormat      = outCtrl_r[ocd_pkg::FMT_MSB:ocd_pkg::FMT_LSB];
	assign dividerPowered = powered_r;
	assign syncBusy       = busy_r;

	// ==========================================================
	// Datapath
	ocd_int_divider #(
		.RW (RATIO_W),
		.DW (DELAY_W)
	) u_div (
		.clk        (clk),
		.rst        (rst),
		.clkEn      (clkEn),
		.prescalerA (prescalerA),
		.prescalerB (prescalerB),
		.fracDivClk (fracDivClk),
		.refClk     (refClk),
		.syncReq    (syncReq),
		.cfg        (cfg.div)
	);

	ocd_out_decoder u_dec (
		.clk    (clk),
		.rst    (rst),
		.clkEn  (clkEn),
		.ch2Clk (ch2Clk),
		.ch4Clk (ch4Clk),
		.outP   (outP),
		.outN   (outN),
		.outPEn (outPEn),
		.outNEn (outNEn),
		.cfg    (cfg.dec)
	);

	// ==========================================================
	// Checks
	sequence s_wr_div;
		clkEn && regWrEn && regAddr == ocd_pkg::ADDR_DIV_CTRL;
	endsequence

	sequence s_sync_armed;
		clkEn && syncReq && cfg.syncEn && !cfg.syncBusy && cfg.ratio != '0 && cfg.syncDelay != '0;
	endsequence

	sequence s_unmuted_cmos;
		clkEn && !cfg.chanMute && cfg.fmt == ocd_pkg::FMT_CMOS_BOTH_PINS && cfg.outSel == ocd_pkg::OSEL_CH2;
	endsequence

	chk_src_select_write: assert property (@(posedge clk) disable iff (rst)
		s_wr_div |=> cfg.srcSel == $past(regWrData[15:14]))
		else $error("source select not taken from write");

	chk_ratio_write_powered: assert property (@(posedge clk) disable iff (rst)
		s_wr_div |=> dividerPowered == (cfg.ratio != '0))
		else $error("powered flag disagrees with ratio");

	chk_ratio_zero_low: assert property (@(posedge clk) disable iff (rst)
		(clkEn && cfg.ratio == '0) [*2] |-> !cfg.chanClk)
		else $error("channel clock runs with zero ratio");

	chk_sync_delay_start: assert property (@(posedge clk) disable iff (rst)
		s_sync_armed |=> cfg.syncBusy && !cfg.chanClk)
		else $error("enabled sync did not start its delay");

	chk_sync_delay_hold: assert property (@(posedge clk) disable iff (rst)
		cfg.syncBusy && clkEn |=> cfg.syncBusy || $past(cfg.ratio) == '0 || $past(u_div.rise))
		else $error("sync delay ended without a source edge");

	chk_sync_disabled_ignored: assert property (@(posedge clk) disable iff (rst)
		clkEn && syncReq && !cfg.syncEn && !cfg.syncBusy |=> !cfg.syncBusy)
		else $error("disabled sync started a delay");

	chk_mute_level_pins: assert property (@(posedge clk) disable iff (rst)
		clkEn && muteOverride && cfg.chanMute && cfg.fmt == ocd_pkg::FMT_LVDS
		|=> outP == $past(cfg.muteLevel) && outN == !$past(cfg.muteLevel))
		else $error("muted pins do not show the mute level");

	chk_mute_override_sel: assert property (@(posedge clk) disable iff (rst)
		clkEn |=> cfg.muteActive == ($past(muteOverride) ? $past(cfg.chanMute)
			: ($past(calibActive) && $past(cfg.chanMute))))
		else $error("internal mute wrong for override and calibration");

	chk_cmos_polarity: assert property (@(posedge clk) disable iff (rst)
		s_unmuted_cmos and !calibActive
		|=> outP == ($past(ch2Clk) ^ $past(cfg.pol[1])) && outN == (!$past(ch2Clk) ^ $past(cfg.pol[0])))
		else $error("CMOS polarity not applied");

	chk_format_disabled: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.fmt == ocd_pkg::FMT_DISABLED |=> !outPEn && !outNEn && !outP && !outN)
		else $error("disabled buffer still drives");

	chk_format_reset: assert property (@(posedge clk)
		rst |=> outFormat == ocd_pkg::FMT_LVDS)
		else $error("buffer format not LVDS after reset");

	chk_out_select_ch4: assert property (@(posedge clk) disable iff (rst)
		clkEn && !cfg.chanMute && cfg.fmt == ocd_pkg::FMT_LVDS && cfg.outSel == ocd_pkg::OSEL_CH4
		|=> outP == $past(ch4Clk) && outN == !$past(ch4Clk))
		else $error("channel four clock not selected");

	sequence s_rd_div;
		clkEn && regRdEn && regAddr == ocd_pkg::ADDR_DIV_CTRL;
	endsequence

	sequence s_wr_out;
		clkEn && regWrEn && regAddr == ocd_pkg::ADDR_OUT_CTRL;
	endsequence

	sequence s_sync_ignored;
		clkEn && syncReq && !cfg.syncEn && !cfg.syncBusy && cfg.ratio != '0;
	endsequence

	chk_src_prescaler_a: assert property (@(posedge clk) disable iff (rst)
		cfg.srcSel == ocd_pkg::SRC_PRESCALER_A |-> u_div.srcLvl == prescalerA)
		else $error("prescaler A not routed to the divider");

	chk_src_prescaler_b: assert property (@(posedge clk) disable iff (rst)
		cfg.srcSel == ocd_pkg::SRC_PRESCALER_B |-> u_div.srcLvl == prescalerB)
		else $error("prescaler B not routed to the divider");

	chk_src_frac_div: assert property (@(posedge clk) disable iff (rst)
		cfg.srcSel == ocd_pkg::SRC_FRAC_DIV |-> u_div.srcLvl == fracDivClk)
		else $error("fractional divider not routed to the divider");

	chk_src_reference: assert property (@(posedge clk) disable iff (rst)
		cfg.srcSel == ocd_pkg::SRC_REF |-> u_div.srcLvl == refClk)
		else $error("reference not routed to the divider");

	chk_div_read_back: assert property (@(posedge clk) disable iff (rst)
		s_rd_div |=> regRdValid && regRdData == $past(divCtrl_r))
		else $error("divider register read back wrong");

	chk_ratio_one_follow: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.ratio == 14'h0001 && !cfg.syncBusy && !(syncReq && cfg.syncEn)
		|=> cfg.chanClk == $past(u_div.srcLvl))
		else $error("ratio of one does not pass the source");

	chk_ratio_count_range: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.ratio != '0 && !cfg.syncBusy && u_div.rise |=> u_div.cnt_r < $past(cfg.ratio))
		else $error("divider count left its range");

	chk_sync_clock_low: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.syncBusy |=> !cfg.chanClk)
		else $error("channel clock ran during the sync delay");

	chk_sync_delay_load: assert property (@(posedge clk) disable iff (rst)
		s_sync_armed |=> u_div.dly_r == $past(cfg.syncDelay))
		else $error("sync delay count not loaded");

	chk_sync_busy_port: assert property (@(posedge clk) disable iff (rst)
		clkEn |=> syncBusy == $past(cfg.syncBusy))
		else $error("busy port does not follow the sync delay");

	chk_sync_count_kept: assert property (@(posedge clk) disable iff (rst)
		s_sync_ignored and !u_div.rise |=> u_div.cnt_r == $past(u_div.cnt_r))
		else $error("disabled sync disturbed the divider count");

	chk_mute_calib_pins: assert property (@(posedge clk) disable iff (rst)
		clkEn && !muteOverride && calibActive && cfg.chanMute && cfg.fmt == ocd_pkg::FMT_LVDS
		|=> outP == $past(cfg.muteLevel) && outN == !$past(cfg.muteLevel))
		else $error("calibration mute not applied to the pins");

	chk_mute_idle_clear: assert property (@(posedge clk) disable iff (rst)
		clkEn && !muteOverride && !calibActive |=> !cfg.muteActive)
		else $error("mute active outside calibration without override");

	chk_lvds_pol_ignored: assert property (@(posedge clk) disable iff (rst)
		clkEn && !cfg.chanMute && cfg.fmt == ocd_pkg::FMT_LVDS && cfg.outSel == ocd_pkg::OSEL_CH2
		|=> outP == $past(ch2Clk) && outN == !$past(ch2Clk))
		else $error("polarity applied to a differential format");

	chk_format_p_only: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.fmt == ocd_pkg::FMT_CMOS_POSITIVE_ONLY |=> outPEn && !outNEn && !outN)
		else $error("positive only format drives the negative pin");

	chk_format_n_only: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.fmt == ocd_pkg::FMT_CMOS_NEGATIVE_ONLY |=> !outPEn && outNEn && !outP)
		else $error("negative only format drives the positive pin");

	chk_format_both_driven: assert property (@(posedge clk) disable iff (rst)
		clkEn && cfg.fmt != ocd_pkg::FMT_DISABLED && cfg.fmt < ocd_pkg::FMT_CMOS_POSITIVE_ONLY |=> outPEn && outNEn)
		else $error("paired format does not drive both pins");

	chk_format_write: assert property (@(posedge clk) disable iff (rst)
		s_wr_out |=> outFormat == $past(regWrData[ocd_pkg::FMT_MSB:ocd_pkg::FMT_LSB]))
		else $error("buffer format not taken from write");

	chk_frozen_write_ignored: assert property (@(posedge clk) disable iff (rst)
		!clkEn && regWrEn |=> $stable(divCtrl_r) && $stable(outCtrl_r))
		else $error("write taken while the clock enable was low");

	chk_out_select_ch3: assert property (@(posedge clk) disable iff (rst)
		clkEn && !cfg.chanMute && cfg.fmt == ocd_pkg::FMT_LVDS && cfg.outSel == ocd_pkg::OSEL_CH3
		|=> outP == $past(cfg.chanClk) && outN == !$past(cfg.chanClk))
		else $error("own channel clock not selected");

	chk_out_select_none: assert property (@(posedge clk) disable iff (rst)
		clkEn && !cfg.chanMute && cfg.fmt == ocd_pkg::FMT_LVDS && cfg.outSel == 2'h3 |=> !outP && outN)
		else $error("unused output select does not drive low");

endmodule // ocd_channel_cfg

/* File: src/ocd_pkg.sv */
// Shared constants for the output channel divider and mux configuration block.
package ocd_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0]  ADDR_DIV_CTRL   = 8'h31;
	localparam logic [7:0]  ADDR_OUT_CTRL   = 8'h32;
	localparam logic [15:0] DIV_CTRL_RESET  = 16'h0000;
	localparam logic [15:0] OUT_CTRL_RESET  = 16'h0004;
	// ==========================================================
	// Divider source and ratio register fields
	localparam int SRC_MSB   = 15;
	localparam int SRC_LSB   = 14;
	localparam int RATIO_MSB = 13;
	localparam int RATIO_LSB = 0;
	// ==========================================================
	// Sync, mute and format register fields
	localparam int DLY_MSB    = 15;
	localparam int DLY_LSB    = 11;
	localparam int SYNCEN_BIT = 10;
	localparam int MLVL_BIT   = 8;
	localparam int MUTE_BIT   = 7;
	localparam int POL_MSB    = 6;
	localparam int POL_LSB    = 5;
	localparam int FMT_MSB    = 4;
	localparam int FMT_LSB    = 2;
	localparam int OSEL_MSB   = 1;
	localparam int OSEL_LSB   = 0;
	// ==========================================================
	// Field encodings
	localparam logic [1:0] SRC_PRESCALER_A = 2'h0;
	localparam logic [1:0] SRC_PRESCALER_B = 2'h1;
	localparam logic [1:0] SRC_FRAC_DIV    = 2'h2;
	localparam logic [1:0] SRC_REF        = 2'h3;
	localparam logic [2:0] FMT_DISABLED           = 3'h0;
	localparam logic [2:0] FMT_LVDS               = 3'h1;
	localparam logic [2:0] FMT_CMOS_BOTH_PINS     = 3'h5;
	localparam logic [2:0] FMT_CMOS_POSITIVE_ONLY = 3'h6;
	localparam logic [2:0] FMT_CMOS_NEGATIVE_ONLY = 3'h7;
	localparam logic [1:0] OSEL_CH2 = 2'h0;
	localparam logic [1:0] OSEL_CH3 = 2'h1;
	localparam logic [1:0] OSEL_CH4 = 2'h2;
endpackage

/* File: src/ocd_cfg_if.sv */
// Configuration and status carrier between the channel's register file and its datapath.
`timescale 1ns/10ps
interface ocd_cfg_if;
	logic [1:0]  srcSel;
	logic [13:0] ratio;
	logic [4:0]  syncDelay;
	logic        syncEn;
	logic        muteLevel;
	logic        chanMute;
	logic        override;
	logic        calib;
	logic [1:0]  pol;
	logic [2:0]  fmt;
	logic [1:0]  outSel;
	logic        chanClk;
	logic        syncBusy;
	logic        muteActive;
	modport ctrl (output srcSel, ratio, syncDelay, syncEn, muteLevel, chanMute, override, calib, pol, fmt,
		outSel, input chanClk, syncBusy, muteActive);
	modport div (input srcSel, ratio, syncDelay, syncEn, output chanClk, syncBusy);
	modport dec (input muteLevel, chanMute, override, calib, pol, fmt, outSel, chanClk, output muteActive);
endinterface

/* File: src/ocd_int_divider.sv */
// Source select, integer divider and synchronization delay of one output channel.
`timescale 1ns/10ps
module ocd_int_divider #(
	parameter int RW = 14,
	parameter int DW = 5
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clkEn,
	input  wire logic prescalerA,
	input  wire logic prescalerB,
	input  wire logic fracDivClk,
	input  wire logic refClk,
	input  wire logic syncReq,
	ocd_cfg_if.div    cfg
);
	typedef enum logic {DIV_RUN, DIV_WAIT} ocd_div_state_t;

	ocd_div_state_t  state_r, state_nxt;
	logic [RW-1:0]   cnt_r, cnt_nxt;
	logic [DW-1:0]   dly_r, dly_nxt;
	logic            srcPrev_r, srcPrev_nxt;
	logic            clk_r, clk_nxt;
	logic            srcLvl;
	logic            rise;
	logic [RW-1:0]   half;

	assign cfg.chanClk  = clk_r;
	assign cfg.syncBusy = (state_r == DIV_WAIT);

	// ==========================================================
	// Next state
	always_comb begin
		case (cfg.srcSel)
			ocd_pkg::SRC_PRESCALER_A: srcLvl = prescalerA;
			ocd_pkg::SRC_PRESCALER_B: srcLvl = prescalerB;
			ocd_pkg::SRC_FRAC_DIV:    srcLvl = fracDivClk;
			default:                  srcLvl = refClk;
		endcase
		rise        = srcLvl & ~srcPrev_r;
		half        = (cfg.ratio >> 1) + {{(RW-1){1'b0}}, cfg.ratio[0]};
		srcPrev_nxt = srcLvl;
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		dly_nxt     = dly_r;
		clk_nxt     = clk_r;
		if (cfg.ratio == '0) begin
			state_nxt = DIV_RUN;
			cnt_nxt   = '0;
			clk_nxt   = 1'b0;
		end else if (state_r == DIV_RUN && syncReq && cfg.syncEn) begin
			cnt_nxt = '0;
			clk_nxt = 1'b0;
			if (cfg.syncDelay != '0) begin
				state_nxt = DIV_WAIT;
				dly_nxt   = cfg.syncDelay;
			end
		end else if (state_r == DIV_WAIT) begin
			// The output stays low while the delay runs so that the restart is clean.
			clk_nxt = 1'b0;
			if (rise) begin
				dly_nxt = dly_r - DW'(1);
				if (dly_r == DW'(1)) begin
					state_nxt = DIV_RUN;
				end
			end
		end else begin
			if (rise) begin
				cnt_nxt = (cnt_r >= cfg.ratio - RW'(1)) ? '0 : cnt_r + RW'(1);
			end
			// A ratio of one cannot be built from counted edges, so the source passes through.
			clk_nxt = (cfg.ratio == RW'(1)) ? srcLvl : (cnt_nxt < half);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r   <= DIV_RUN;
			cnt_r     <= '0;
			dly_r     <= '0;
			srcPrev_r <= 1'b0;
			clk_r     <= 1'b0;
		end else if (clkEn) begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			dly_r     <= dly_nxt;
			srcPrev_r <= srcPrev_nxt;
			clk_r     <= clk_nxt;
		end
	end
endmodule // ocd_int_divider

/* File: src/ocd_out_decoder.sv */
// Output clock select, mute, polarity and buffer format decoding for one output pin pair.
`timescale 1ns/10ps
module ocd_out_decoder (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clkEn,
	input  wire logic ch2Clk,
	input  wire logic ch4Clk,
	output logic      outP,
	output logic      outN,
	output logic      outPEn,
	output logic      outNEn,
	ocd_cfg_if.dec    cfg
);
	logic outP_nxt, outN_nxt, outPEn_nxt, outNEn_nxt, mute_r, mute_nxt;
	logic selClk;

	assign cfg.muteActive = mute_r;

	// ==========================================================
	// Next state
	always_comb begin
		case (cfg.outSel)
			ocd_pkg::OSEL_CH2: selClk = ch2Clk;
			ocd_pkg::OSEL_CH3: selClk = cfg.chanClk;
			ocd_pkg::OSEL_CH4: selClk = ch4Clk;
			default:           selClk = 1'b0;
		endcase
		mute_nxt = cfg.override ? cfg.chanMute : (cfg.calib & cfg.chanMute);
		if (mute_nxt) begin
			outP_nxt = cfg.muteLevel;
			outN_nxt = ~cfg.muteLevel;
		end else begin
			outP_nxt = selClk;
			outN_nxt = ~selClk;
			if (cfg.fmt >= ocd_pkg::FMT_CMOS_BOTH_PINS) begin
				outP_nxt = outP_nxt ^ cfg.pol[1];
				outN_nxt = outN_nxt ^ cfg.pol[0];
			end
		end
		case (cfg.fmt)
			ocd_pkg::FMT_DISABLED: begin
				outPEn_nxt = 1'b0;
				outNEn_nxt = 1'b0;
			end
			ocd_pkg::FMT_CMOS_POSITIVE_ONLY: begin
				outPEn_nxt = 1'b1;
				outNEn_nxt = 1'b0;
			end
			ocd_pkg::FMT_CMOS_NEGATIVE_ONLY: begin
				outPEn_nxt = 1'b0;
				outNEn_nxt = 1'b1;
			end
			default: begin
				outPEn_nxt = 1'b1;
				outNEn_nxt = 1'b1;
			end
		endcase
		// An undriven pin is held low so that nothing toggles behind a disabled buffer.
		outP_nxt = outP_nxt & outPEn_nxt;
		outN_nxt = outN_nxt & outNEn_nxt;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			outP   <= 1'b0;
			outN   <= 1'b0;
			outPEn <= 1'b0;
			outNEn <= 1'b0;
			mute_r <= 1'b0;
		end else if (clkEn) begin
			outP   <= outP_nxt;
			outN   <= outN_nxt;
			outPEn <= outPEn_nxt;
			outNEn <= outNEn_nxt;
			mute_r <= mute_nxt;
		end
	end
endmodule // ocd_out_decoder

/* File: test/ocd_clock_receiver.sv */
// Behavioural clock receiver that terminates the channel's output pin pair.
`timescale 1ns/10ps
module ocd_clock_receiver (
	input  wire logic clk,
	input  wire logic outP,
	input  wire logic outN,
	input  wire logic outPEn,
	input  wire logic outNEn,
	output logic      rxP,
	output logic      rxN,
	output int        risingP
);
	// ==========================================================
	// Termination and edge counting
	// An undriven pin is pulled low by the termination, so a disabled pin never echoes its last level.
	logic prevP;
	assign rxP = outPEn ? outP : 1'b0;
	assign rxN = outNEn ? outN : 1'b0;
	initial begin
		risingP = 0;
		prevP = 1'b0;
	end
	always @(posedge clk) begin
		if (rxP && !prevP)
			risingP <= risingP + 1;
		prevP <= rxP;
	end
endmodule // ocd_clock_receiver

/* File: test/output_channel_divider_mux_cfg_test.sv */
// Self-checking testbench of the output channel divider and mux configuration block.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errCount++; \
	$display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module output_channel_divider_mux_cfg_test;
	// ==========================================================
	// Signals
	logic clk, rst, clkEn, regWrEn, regRdEn, syncReq, calibActive, muteOverride, ch2Clk, ch4Clk;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData, d;
	logic [3:0] src;
	logic [3:0] phase;
	logic regRdValid, outP, outN, outPEn, outNEn, dividerPowered, syncBusy, rxP, rxN;
	logic [2:0] outFormat;
	int errCount, comparisons, risingP, srcIdx, c0, r, busy;
	ocd_channel_cfg dut (.clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.prescalerA(src[0]), .prescalerB(src[1]), .fracDivClk(src[2]), .refClk(src[3]), .syncReq(syncReq),
		.calibActive(calibActive), .muteOverride(muteOverride), .ch2Clk(ch2Clk), .ch4Clk(ch4Clk),
		.outP(outP), .outN(outN), .outPEn(outPEn), .outNEn(outNEn), .outFormat(outFormat),
		.dividerPowered(dividerPowered), .syncBusy(syncBusy));
	ocd_clock_receiver rx (.clk(clk), .outP(outP), .outN(outN), .outPEn(outPEn), .outNEn(outNEn),
		.rxP(rxP), .rxN(rxN), .risingP(risingP));
	// ==========================================================
	// Clock, source clocks and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Only the source under test toggles, so a wrong selector shows up as a silent channel.
	always @(posedge clk) begin
		phase <= phase + 4'h1;
		for (int i = 0; i < 4; i++)
			src[i] <= (i == srcIdx) ? phase[1] : 1'b0;
	end
	initial begin
		#(20 * 20000);
		errCount++;
		finalReport();
	end
	// ==========================================================
	// Tasks and expectations
	task automatic finalReport();
		$display("Comparisons %0d, mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		`CHK(regRdValid, 1'b1)
		`CHK(regRdData, e)
	endtask
	task automatic cfg(input logic [15:0] v);
		wr(8'h32, v);
		repeat (3) @(posedge clk);
		#1;
	endtask
	function automatic logic [1:0] expEn(input logic [2:0] f);
		return (f == 3'h0) ? 2'h0 : (f == 3'h6) ? 2'h2 : (f == 3'h7) ? 2'h1 : 2'h3;
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		{rst, clkEn, regWrEn, regRdEn, syncReq, calibActive, muteOverride, ch2Clk, ch4Clk} = 9'h100;
		{regAddr, regWrData, phase, src, srcIdx, errCount, comparisons} = '0;
		clkEn = 1'b1;
		r = $urandom(2);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(outFormat, 3'h1)
		`CHK(dividerPowered, 1'b0)
		rd(8'h31, 16'h0000);
		rd(8'h32, 16'h0004);
		for (int i = 0; i < 8; i++) begin
			d = 16'($urandom);
			wr(8'h31, d);
			rd(8'h31, d);
			wr(8'h32, d);
			rd(8'h32, d & 16'hfdff);
			rd(8'h33 + 8'($urandom % 8), 16'h0000);
		end
		// A frozen clock enable must swallow the write.
		wr(8'h31, 16'h0000);
		clkEn <= 1'b0;
		wr(8'h31, 16'h1234);
		clkEn <= 1'b1;
		rd(8'h31, 16'h0000);
		for (int f = 0; f < 8; f++) begin
			cfg(16'(f << 2));
			`CHK(outFormat, 3'(f))
			`CHK({outPEn, outNEn, outP, outN}, {expEn(3'(f)), 1'b0, 1'(expEn(3'(f)))})
		end
		ch2Clk <= 1'b1;
		cfg(16'h0004);
		`CHK({outP, outN}, 2'h2)
		cfg(16'h0006);
		`CHK({outP, outN}, 2'h1)
		ch4Clk <= 1'b1;
		cfg(16'h0006);
		`CHK({outP, outN}, 2'h2)
		cfg(16'h0007);
		`CHK({outP, outN}, 2'h1)
		ch2Clk <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			cfg(16'h0014 | 16'(p << 5));
			`CHK({outP, outN}, {1'(p >> 1), ~1'(p)})
		end
		muteOverride <= 1'b1;
		cfg(16'h0084);
		`CHK({rxP, rxN}, 2'h1)
		cfg(16'h0184);
		`CHK({rxP, rxN}, 2'h2)
		muteOverride <= 1'b0;
		cfg(16'h0184);
		`CHK({rxP, rxN}, 2'h1)
		calibActive <= 1'b1;
		cfg(16'h0184);
		`CHK({rxP, rxN}, 2'h2)
		calibActive <= 1'b0;
		// Each source in turn through a random ratio; the source rises once every four cycles.
		cfg(16'h0005);
		for (int s = 0; s < 4; s++) begin
			r = 1 + $urandom % 5;
			srcIdx <= s;
			wr(8'h31, 16'(s << 14) | 16'(r));
			repeat (20) @(posedge clk);
			c0 = risingP;
			repeat (240) @(posedge clk);
			#1;
			`CHK(dividerPowered, 1'b1)
			`CHK((risingP - c0 >= 60 / r - 1) && (risingP - c0 <= 60 / r + 1), 1'b1)
		end
		wr(8'h31, 16'hc000);
		repeat (4) @(posedge clk);
		c0 = risingP;
		repeat (60) @(posedge clk);
		#1;
		`CHK(dividerPowered, 1'b0)
		`CHK(risingP - c0, 0)
		srcIdx <= 0;
		wr(8'h31, 16'h0002);
		for (int e = 1; e >= 0; e--) begin
			r = 2 + $urandom % 6;
			cfg(16'(r << 11) | 16'(e << 10) | 16'h0005);
			@(posedge clk);
			syncReq <= 1'b1;
			@(posedge clk);
			syncReq <= 1'b0;
			busy = 0;
			repeat (200) begin
				@(posedge clk);
				#1;
				busy += int'(syncBusy === 1'b1);
			end
			`CHK((busy >= e * (4 * r - 4)) && (busy <= e * (4 * r + 4)), 1'b1)
		end
		`CHK(busy, 0)
		finalReport();
	end
endmodule // output_channel_divider_mux_cfg_test
